// *** design/qdsl_consts.svh ***
// constants of the quad converter serial load front end
`ifndef QDSL_CONSTS_SVH
`define QDSL_CONSTS_SVH

// ---------------------------------------------------------------
// word and field layout
// ---------------------------------------------------------------
`define QDSL_WORD_W     16
`define QDSL_CODE_W     12
`define QDSL_CODE_LSB   0
`define QDSL_CH_N       4
`define QDSL_CH_W       2
`define QDSL_CH_LSB     12

// ---------------------------------------------------------------
// bit counter of the serial link
// ---------------------------------------------------------------
`define QDSL_CNT_W      4
`define QDSL_CNT_LAST   4'hF

// ---------------------------------------------------------------
// clear presets
// ---------------------------------------------------------------
`define QDSL_CODE_ZERO  12'h000
`define QDSL_CODE_MID   12'h800

// ---------------------------------------------------------------
// word buffer between link and core
// ---------------------------------------------------------------
`define QDSL_FIFO_DEPTH 16
`define QDSL_FIFO_AW    4

`endif

// *** design/qdsl_pkg.sv ***
// types of the quad converter serial load front end
`include "qdsl_consts.svh"

package qdsl_pkg;

	typedef logic [`QDSL_WORD_W-1:0] qdsl_word_t;
	typedef logic [`QDSL_CODE_W-1:0] qdsl_code_t;
	typedef logic [`QDSL_CH_W-1:0]   qdsl_ch_t;
	typedef qdsl_code_t [`QDSL_CH_N-1:0] qdsl_codes_t;

	// serial pins sampled on the link clock
	typedef struct packed {
		logic cs_n;
		logic serial_data_in;
	} qdsl_link_t;

	// asynchronous control pins of the core
	typedef struct packed {
		logic load_outputs_n;
		logic clear_n;
		logic clear_level_select;
	} qdsl_ctrl_t;

	// state on the link clock
	typedef struct packed {
		qdsl_word_t             shift;
		logic [`QDSL_CNT_W-1:0] cnt;
		qdsl_word_t             hold;
		logic                   tog;
	} qdsl_link_st_t;

	// state on the core clock
	typedef struct packed {
		logic        tog_s1;
		logic        tog_s2;
		logic        tog_s3;
		logic        pend;
		qdsl_word_t  catch_word;
		logic        ld_s1;
		logic        ld_s2;
		logic        ld_s3;
		logic        clr_s1;
		logic        clr_s2;
		logic        sel_s1;
		logic        sel_s2;
		qdsl_word_t  sir;
		qdsl_code_t  input_code;
		qdsl_codes_t dac;
	} qdsl_core_st_t;

endpackage

// *** design/qdsl_top.sv ***
// serial load and clear front end of a quad converter, with word buffer
`timescale 1ns/100ps
`default_nettype none
`include "qdsl_consts.svh"

// ---------------------------------------------------------------
// word buffer
// ---------------------------------------------------------------
module qdsl_fifo #(
	parameter int W  = `QDSL_WORD_W,
	parameter int D  = `QDSL_FIFO_DEPTH,
	parameter int AW = `QDSL_FIFO_AW
) (
	input  wire logic         clk,       // core clock
	input  wire logic         rst,       // synchronous-released reset, high
	input  wire logic         in_valid,  // word offered
	output logic              in_ready,  // space left
	input  wire logic [W-1:0] in_data,   // word in
	output logic              out_valid, // word waiting
	input  wire logic         out_ready, // consumer takes word
	output logic [W-1:0]      out_data   // oldest word
);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0]         wp;
		logic [AW:0]         rp;
	} qdsl_fifo_st_t;

	qdsl_fifo_st_t s;
	qdsl_fifo_st_t next_s;
	logic          full;
	logic          empty;

	assign empty     = (s.wp == s.rp);
	assign full      = (s.wp[AW] != s.rp[AW])
		&& (s.wp[AW-1:0] == s.rp[AW-1:0]);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = s.mem[s.rp[AW-1:0]];

	always_comb begin
		next_s = s;
		if (in_valid && !full) begin
			next_s.mem[s.wp[AW-1:0]] = in_data;
			next_s.wp = s.wp + 1'b1;
		end
		if (out_ready && !empty) begin
			next_s.rp = s.rp + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	AST_FIFO_FULL: assert property (@(posedge clk) disable iff (rst)
		full && !(out_ready && !empty) |=> full && !in_ready)
		else $error("buffer lost its full state without a read");
endmodule // qdsl_fifo

// Function
// - data bit sampled on rising serial clock
// - select high leaves shift register unchanged
// - each qualified edge shifts one bit in
// - select low enables clocking, high blocks it
// - load falling edge copies the code to the addressed channel
// - clear forces input and channel registers preset
// - clear leaves serial input register untouched
// - select high gives midscale, low gives zero
// - one transfer carries a sixteen bit word
module qdsl_top
	import qdsl_pkg::*;
(
	input  wire logic       clk,        // core clock
	input  wire logic       rst_n,      // asynchronous reset, low
	input  wire logic       sclk,       // serial link clock
	input  wire qdsl_link_t link,       // select and serial data
	input  wire qdsl_ctrl_t ctrl,       // load, clear, clear level
	output logic            word_ready, // buffer can take a word
	output qdsl_word_t      shift_word, // serial input register
	output qdsl_code_t      input_code, // input register
	output qdsl_codes_t     dac_code    // channel data registers
);
	import qdsl_pkg::*;

	// ---------------------------------------------------------------
	// reset release in both domains
	// ---------------------------------------------------------------
	logic [1:0] rst_q;
	logic [1:0] lrst_q;
	logic       rst;
	logic       lrst;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			lrst_q <= 2'h0;
		end else begin
			lrst_q <= {lrst_q[0], 1'b1};
		end
	end

	assign rst  = !rst_q[1];
	assign lrst = !lrst_q[1];

	// ---------------------------------------------------------------
	// link domain: shift register on the serial clock
	// ---------------------------------------------------------------
	qdsl_link_st_t lk;
	qdsl_link_st_t next_lk;
	qdsl_word_t    shifted;

	assign shifted = {lk.shift[`QDSL_WORD_W-2:0], link.serial_data_in};

	always_comb begin
		next_lk = lk;
		if (!link.cs_n) begin
			next_lk.shift = shifted;
			next_lk.cnt   = lk.cnt + 1'b1;
			if (lk.cnt == `QDSL_CNT_LAST) begin
				next_lk.hold = shifted;
				next_lk.tog  = !lk.tog;
			end
		end
	end

	always_ff @(posedge sclk or posedge lrst) begin
		if (lrst) begin
			lk <= '0;
		end else begin
			lk <= next_lk;
		end
	end

	AST_SHIFT: assert property (
		@(posedge sclk) disable iff (lrst)
		!link.cs_n |=> lk.shift == {$past(lk.shift[`QDSL_WORD_W-2:0]),
			$past(link.serial_data_in)})
		else $error("qualified edge did not shift the data bit in");

	AST_CS_BLOCK: assert property (
		@(posedge sclk) disable iff (lrst)
		link.cs_n |=> $stable(lk.shift) && $stable(lk.cnt)
			&& $stable(lk.tog))
		else $error("serial register moved while deselected");

	AST_WORD: assert property (
		@(posedge sclk) disable iff (lrst)
		!link.cs_n && lk.cnt == `QDSL_CNT_LAST
			|=> lk.tog != $past(lk.tog) && lk.hold == lk.shift)
		else $error("sixteenth bit did not complete a word");

	AST_MSB_FIRST: assert property (
		@(posedge sclk) disable iff (lrst)
		!link.cs_n && lk.cnt == `QDSL_CNT_LAST
			|=> lk.hold[`QDSL_WORD_W-1] == $past(lk.shift[`QDSL_WORD_W-2]))
		else $error("first bit of a word did not land in the top bit");

	// ---------------------------------------------------------------
	// core domain: crossing, buffer, load and clear
	// ---------------------------------------------------------------
	qdsl_core_st_t c;
	qdsl_core_st_t next_c;
	qdsl_code_t    next_code [`QDSL_CH_N];
	logic          word_arrive;
	logic          push_ready;
	logic          pop_valid;
	logic          pop_ready;
	qdsl_word_t    pop_data;
	logic          ld_fall;
	logic          clr_act;
	qdsl_code_t    preset;
	qdsl_ch_t      ch_sel;
	qdsl_code_t    sir_code;

	localparam qdsl_core_st_t CORE_RST = '{
		ld_s1:  1'b1,
		ld_s2:  1'b1,
		ld_s3:  1'b1,
		clr_s1: 1'b1,
		clr_s2: 1'b1,
		default: '0
	};

	assign word_arrive = c.tog_s2 ^ c.tog_s3;
	assign ld_fall     = c.ld_s3 && !c.ld_s2;
	assign clr_act     = !c.clr_s2;
	assign preset      = c.sel_s2 ? `QDSL_CODE_MID : `QDSL_CODE_ZERO;
	assign ch_sel      = c.sir[`QDSL_CH_LSB +: `QDSL_CH_W];
	assign sir_code    = c.sir[`QDSL_CODE_LSB +: `QDSL_CODE_W];
	// the register feeding the channels stays put while load is low
	assign pop_ready   = c.ld_s2;
	assign word_ready  = push_ready;

	qdsl_fifo #(
		.W  (`QDSL_WORD_W),
		.D  (`QDSL_FIFO_DEPTH),
		.AW (`QDSL_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (c.pend),
		.in_ready  (push_ready),
		.in_data   (c.catch_word),
		.out_valid (pop_valid),
		.out_ready (pop_ready),
		.out_data  (pop_data)
	);

	// per channel: clear beats load, load hits the addressed channel
	for (genvar i = 0; i < `QDSL_CH_N; i++) begin : g_ch
		localparam qdsl_ch_t CH_ID = `QDSL_CH_W'(i);

		always_comb begin
			next_code[i] = c.dac[i];
			if (clr_act) begin
				next_code[i] = preset;
			end else if (ld_fall && ch_sel == CH_ID) begin
				next_code[i] = sir_code;
			end
		end

		AST_CLR_CH: assert property (
			@(posedge clk) disable iff (rst)
			clr_act |=> c.dac[i] == $past(preset))
			else $error("channel not preset during clear");

		AST_LOAD_CH: assert property (
			@(posedge clk) disable iff (rst)
			ld_fall && !clr_act && ch_sel != CH_ID |=> $stable(c.dac[i]))
			else $error("load changed a channel it did not address");
	end

	always_comb begin
		next_c = c;
		// level and event crossings into the core clock
		next_c.tog_s1 = lk.tog;
		next_c.tog_s2 = c.tog_s1;
		next_c.tog_s3 = c.tog_s2;
		next_c.ld_s1  = ctrl.load_outputs_n;
		next_c.ld_s2  = c.ld_s1;
		next_c.ld_s3  = c.ld_s2;
		next_c.clr_s1 = ctrl.clear_n;
		next_c.clr_s2 = c.clr_s1;
		next_c.sel_s1 = ctrl.clear_level_select;
		next_c.sel_s2 = c.sel_s1;
		// the held word is stable for sixteen link edges after the toggle
		if (word_arrive) begin
			next_c.catch_word = lk.hold;
			next_c.pend       = 1'b1;
		end else if (c.pend && push_ready) begin
			next_c.pend = 1'b0;
		end
		// the serial input register ignores clear
		if (pop_valid && pop_ready) begin
			next_c.sir = pop_data;
		end
		if (clr_act) begin
			next_c.input_code = preset;
		end else if (pop_valid && pop_ready) begin
			next_c.input_code = pop_data[`QDSL_CODE_LSB +: `QDSL_CODE_W];
		end
		for (int k = 0; k < `QDSL_CH_N; k++) begin
			next_c.dac[k] = next_code[k];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			c <= CORE_RST;
		end else begin
			c <= next_c;
		end
	end

	assign shift_word = c.sir;
	assign input_code = c.input_code;
	assign dac_code   = c.dac;

	// ---------------------------------------------------------------
	// core checks
	// ---------------------------------------------------------------
	sequence seq_load_fall;
		c.ld_s3 && !c.ld_s2 && c.clr_s2;
	endsequence

	sequence seq_clear_hold;
		clr_act [*2];
	endsequence

	AST_LOAD: assert property (
		@(posedge clk) disable iff (rst)
		seq_load_fall |=> c.dac[$past(ch_sel)] == $past(sir_code))
		else $error("load edge did not copy the word to its channel");

	AST_LOAD_ONLY_EDGE: assert property (
		@(posedge clk) disable iff (rst)
		!ld_fall && !clr_act |=> $stable(c.dac))
		else $error("channel changed without load or clear");

	AST_CLR_INPUT: assert property (
		@(posedge clk) disable iff (rst)
		seq_clear_hold |-> c.input_code == $past(preset))
		else $error("input register not preset during clear");

	AST_CLR_LEVEL: assert property (
		@(posedge clk) disable iff (rst)
		clr_act && c.sel_s2 |=> c.input_code == `QDSL_CODE_MID)
		else $error("clear with select high did not give midscale");

	AST_CLR_ZERO: assert property (
		@(posedge clk) disable iff (rst)
		clr_act && !c.sel_s2 |=> c.input_code == `QDSL_CODE_ZERO)
		else $error("clear with select low did not give zero");

	AST_SIR_KEEP: assert property (
		@(posedge clk) disable iff (rst)
		clr_act && !(pop_valid && pop_ready) |=> $stable(c.sir))
		else $error("clear disturbed the serial input register");

	AST_LOAD_STABLE: assert property (
		@(posedge clk) disable iff (rst)
		!c.ld_s2 |=> $stable(c.sir))
		else $error("word feeding the channels moved while load low");

	AST_ARRIVE: assert property (
		@(posedge clk) disable iff (rst)
		word_arrive |=> c.pend ##0 c.catch_word == $past(lk.hold))
		else $error("completed word not taken into the core");
endmodule // qdsl_top

`default_nettype wire

// *** tb/qdsl_host.sv ***
// host model that drives the three-wire serial link
`timescale 1ns/100ps
`default_nettype none

module qdsl_host (
	output var logic               sclk, // link clock, still outside frames
	output var qdsl_pkg::qdsl_link_t link  // select and serial data
);
	import qdsl_pkg::*;

	initial begin
		sclk = 1'b0;
		link = '{cs_n: 1'b1, serial_data_in: 1'b0};
	end

	// ---------------------------------------------------------------
	// one frame of sixteen bits, msb first
	// ---------------------------------------------------------------
	task automatic send(input qdsl_word_t w, input logic sel_n);
		#7;
		for (int i = 15; i >= 0; i--) begin
			link.cs_n = sel_n;
			link.serial_data_in = w[i];
			#32 sclk = 1'b1;
			#32 sclk = 1'b0;
		end
		// released line shows the inverse, then stays still
		link.cs_n = 1'b1;
		link.serial_data_in = ~w[0];
	endtask
endmodule // qdsl_host

`default_nettype wire

// *** tb/quad_dac_serial_load_clear_test.sv ***
// self-checking bench of the quad converter serial load front end
`timescale 1ns/100ps
`default_nettype none
`include "qdsl_consts.svh"

module quad_dac_serial_load_clear_test;
	import qdsl_pkg::*;

	logic        clk;
	logic        rst_n;
	logic        sclk;
	logic        word_ready;
	qdsl_link_t  link;
	qdsl_ctrl_t  ctrl;
	qdsl_word_t  shift_word;
	qdsl_code_t  input_code;
	qdsl_codes_t dac_code;
	qdsl_codes_t expd;
	int          fails     = 0;
	int          tests_run = 0;
	int          cycles    = 0;

	qdsl_host host (.sclk(sclk), .link(link));

	qdsl_top dut (
		.clk(clk), .rst_n(rst_n), .sclk(sclk), .link(link), .ctrl(ctrl),
		.word_ready(word_ready), .shift_word(shift_word),
		.input_code(input_code), .dac_code(dac_code)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic conclude();
		$display("tests_run %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			conclude();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// callers sample at the falling edge, away from the launching edge
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			fails++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	task automatic wait_word(input qdsl_word_t w);
		int n;
		n = 0;
		while (shift_word !== w && n < 60) begin
			@(posedge clk);
			n++;
		end
		cyc(1);
	endtask

	task automatic load_pulse();
		ctrl.load_outputs_n <= 1'b0;
		cyc(5);
		ctrl.load_outputs_n <= 1'b1;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_shift();
		host.send(16'hDABC, 1'b0);
		wait_word(16'hDABC);
		@(negedge clk);
		chk(shift_word === 16'hDABC && input_code === 12'hABC, "shift");
		$display("test shift done");
	endtask

	task automatic t_select();
		host.send(16'h5555, 1'b1);
		cyc(10);
		@(negedge clk);
		chk(shift_word === 16'hDABC, "select high shifted");
		host.send(16'h2123, 1'b0);
		wait_word(16'h2123);
		@(negedge clk);
		chk(shift_word === 16'h2123, "frame after idle");
		$display("test select done");
	endtask

	task automatic t_load();
		qdsl_word_t w;
		for (int c = 0; c < 4; c++) begin
			w = {2'b11, 2'(c), 12'h7F0 + 12'(c)};
			host.send(w, 1'b0);
			wait_word(w);
			load_pulse();
			expd[c] = w[11:0];
			@(negedge clk);
			chk(dac_code === expd, "load channel");
			cyc(3);
		end
		$display("test load done");
	endtask

	task automatic t_clear();
		qdsl_code_t p;
		for (int s = 1; s >= 0; s--) begin
			p = s ? `QDSL_CODE_MID : `QDSL_CODE_ZERO;
			ctrl.clear_level_select <= 1'(s);
			cyc(3);
			ctrl.clear_n <= 1'b0;
			cyc(4);
			@(negedge clk);
			chk(dac_code === {4{p}} && input_code === p, "clear");
			chk(shift_word === 16'hF7F3, "clear kept shift");
			cyc(1);
			// a load edge inside a clear must not reach the channels
			load_pulse();
			@(negedge clk);
			chk(dac_code === {4{p}}, "load during clear");
			cyc(1);
			ctrl.clear_n <= 1'b1;
			cyc(3);
		end
		$display("test clear done");
	endtask

	task automatic t_fifo();
		ctrl.load_outputs_n <= 1'b0;
		cyc(5);
		for (int i = 0; i < 16; i++)
			host.send(16'h0100 + 16'(i), 1'b0);
		cyc(8);
		@(negedge clk);
		chk(word_ready === 1'b0 && shift_word === 16'hF7F3
			&& dac_code === {12'h7F3, 36'h0}, "full");
		cyc(1);
		ctrl.load_outputs_n <= 1'b1;
		wait_word(16'h010F);
		@(negedge clk);
		chk(shift_word === 16'h010F && word_ready === 1'b1, "drain");
		$display("test fifo done");
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		ctrl  = '{load_outputs_n: 1'b1, clear_n: 1'b1, clear_level_select: 1'b0};
		expd  = '0;
		cyc(2);
		rst_n <= 1'b1;
		host.send(16'h0000, 1'b1);
		cyc(2);
		t_shift();
		t_select();
		t_load();
		t_clear();
		t_fifo();
		conclude();
	end
endmodule // quad_dac_serial_load_clear_test

`default_nettype wire
